// >>> tac_cfg.svh
// Purpose: constants for traffic announcement control
// Assumes: included by bare name
// Notes: all counts and offsets are macros
`ifndef TAC_CFG_SVH
`define TAC_CFG_SVH
`define TAC_CLK_HZ 25000000
`define TAC_NAME_SYNC_MS 400
`define TAC_NAME_SYNC_CYC ((`TAC_CLK_HZ / 1000) * `TAC_NAME_SYNC_MS)
`define TAC_NETS 4
`define TAC_NAME_LEN 8
`define TAC_ADDR_W 4
// register offsets
`define TAC_REG_CTRL 4'h0
`define TAC_REG_TMOUT 4'h1
`define TAC_REG_NET_EN 4'h2
`define TAC_REG_NET_TP 4'h3
`define TAC_REG_NET_TA 4'h4
`define TAC_REG_STATUS 4'h5
`define TAC_REG_MINLEFT 4'h6
`define TAC_REG_NAME_LO 4'h8
`define TAC_REG_NAME_HI 4'h9
// ctrl fields
`define TAC_CTRL_TA 0
`define TAC_CTRL_TP 1
`define TAC_CTRL_PROG_SW 2
`define TAC_CTRL_NET1_PIN 3
// timeout fields
`define TAC_TMOUT_RISE 7
`define TAC_TMOUT_RST 8'h00
`endif

// >>> tac_pin_sync.sv
// Purpose: two-stage synchroniser with edge detect for the switch pin
// Assumes: pin is asynchronous to ref_clk
// Notes: stage two and the registered level both feed the edge logic
`timescale 1ns/1ps
`default_nettype none
module tac_pin_sync (
   input wire logic ref_clk, // clock
   input wire logic reset_n, // sync reset, active low
   input wire logic pin_in, // raw switch pin
   output logic level_q, // synchronised level
   output logic fall_q, // one-cycle falling edge
   output logic rise_q // one-cycle rising edge
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic level_d, fall_d, rise_d;

   always_comb begin
      meta_d = pin_in;
      sync_d = meta_q;
      level_d = sync_q;
      fall_d = level_q & ~sync_q;
      rise_d = ~level_q & sync_q;
   end

   // see R19
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         level_q <= 1'b1;
         fall_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         level_q <= level_d;
         fall_q <= fall_d;
         rise_q <= rise_d;
      end
   end
endmodule
`default_nettype wire

// >>> tac_pkg.sv
// Purpose: types for traffic announcement control
// Assumes: nothing
// Notes: constants live in tac_cfg.svh
package tac_pkg;
   typedef enum logic [1:0] {
      TAC_IDLE,
      TAC_PIN_LEVEL,
      TAC_PIN_TIMED,
      TAC_CMD
   } tac_src_e;
   typedef logic [3:0] tac_addr_t;
   typedef logic [31:0] tac_data_t;
endpackage

// >>> tac_switch_model.sv
// Purpose: studio traffic switch contact seen from the encoder pin
// Assumes: contact closes to ground, pin has a pull-up
// Notes: unwired contact leaves the pin at the pull-up level
`timescale 1ns/1ps
`default_nettype none
module tac_switch_model (
   input wire logic press, // contact closed
   input wire logic wired, // contact cable present
   output logic pin // level at the encoder pin
);
   // ------------------------------------------------------------
   // contact
   // ------------------------------------------------------------
   // closed pulls low, open or unwired floats high
   // odd delay keeps the async edge off the clock edge
   assign #7 pin = (press && wired) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// >>> tac_top.sv
// Purpose: traffic announcement flag control for an encoder
// Assumes: minute_tick is a one-cycle pulse on ref_clk
// Notes: registers on a simple strobe port, read data one cycle later
// Overview of operation
// R1: pin-held announcement ignores command writes
// R2: command-held announcement ignores the pin
// R3: program switch clears the announcement flag
// R4: timeout zero: pin low level sets flag
// R5: timeout 1-127: falling edge sets, minutes clear
// R6: plus 128: rising edge also clears early
// R7: timeout expires only on minute ticks
// R8: net1 pin control is level only
// R9: traffic program zero forces timeout zero
// R10: net flag refused without tp and enable
// R11: pin may drive net1 announcement flag
// R12: any net flag requests 14B groups
// R13: eight-char traffic name, empty disables
// R14: host waits 400 ms after name write
// R15: net flags excluded from stored data
// R16: per-network link enable bit
// R17: net flag steers receivers to that net
// R18: per-network traffic program flag
// R19: pin double-synchronised before use
// R20: minute counter loads on set, clears
`timescale 1ns/1ps
`default_nettype none
`include "tac_cfg.svh"
module tac_top (
   input wire logic ref_clk, // 25 MHz clock
   input wire logic reset_n, // sync reset, active low
   input wire logic ta_pin, // studio switch, low active
   input wire logic minute_tick, // rtc minute pulse
   input wire tac_pkg::tac_addr_t reg_addr, // register index
   input wire tac_pkg::tac_data_t reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output tac_pkg::tac_data_t reg_rdata, // read data
   output logic ta_flag, // announcement flag out
   output logic tp_flag, // traffic program flag out
   output logic [`TAC_NETS-1:0] other_net_announce_flag, // net flags
   output logic eon_group_req, // request 14B groups
   output logic name_active, // send traffic name now
   output logic name_busy // name sync in progress
);
   import tac_pkg::*;

   // ----------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------
   logic pin_lvl, pin_fall, pin_rise;
   tac_pin_sync u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin_in(ta_pin),
      .level_q(pin_lvl),
      .fall_q(pin_fall),
      .rise_q(pin_rise)
   );

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   tac_src_e src_q, src_d;
   logic tp_q, tp_d;
   logic cmd_ta_q, cmd_ta_d;
   logic net1_pin_q, net1_pin_d;
   logic [7:0] tmout_q, tmout_d;
   logic [6:0] min_left_q, min_left_d;
   logic [`TAC_NETS-1:0] net_en_q, net_en_d;
   logic [`TAC_NETS-1:0] net_tp_q, net_tp_d;
   logic [`TAC_NETS-1:0] net_ta_q, net_ta_d;
   logic [63:0] name_q, name_d;
   logic [23:0] sync_cnt_q, sync_cnt_d;
   tac_data_t rdata_q, rdata_d;
   logic ta_d, eon_d, name_act_d, busy_d;
   logic [`TAC_NETS-1:0] net_out_d;

   function automatic logic hit(input tac_addr_t a, input tac_addr_t r);
      hit = reg_wr && (a == r);
   endfunction

   function automatic logic [`TAC_NETS-1:0] net_guard(
      input logic [`TAC_NETS-1:0] v,
      input logic [`TAC_NETS-1:0] en,
      input logic [`TAC_NETS-1:0] tp);
      net_guard = v & en & tp;
   endfunction

   logic [6:0] tm_min;
   logic tm_rise, prog_sw;
   assign tm_min = tmout_q[6:0];
   assign tm_rise = tmout_q[`TAC_TMOUT_RISE];
   assign prog_sw = hit(reg_addr, `TAC_REG_CTRL)
      && reg_wdata[`TAC_CTRL_PROG_SW];

   // ----------------------------------------------------------
   // announcement flag source machine
   // ----------------------------------------------------------
   always_comb begin
      src_d = src_q;
      cmd_ta_d = cmd_ta_q;
      min_left_d = min_left_q;
      case (src_q)
         TAC_IDLE: begin
            if (hit(reg_addr, `TAC_REG_CTRL)
               && reg_wdata[`TAC_CTRL_TA]
               && !reg_wdata[`TAC_CTRL_PROG_SW]) begin
               src_d = TAC_CMD;
            end else if (!net1_pin_q) begin
               if (tm_min == 7'h00 && !pin_lvl) begin
                  src_d = TAC_PIN_LEVEL; // see R4
               end else if (tm_min != 7'h00 && pin_fall) begin
                  src_d = TAC_PIN_TIMED; // see R5
                  min_left_d = tm_min; // see R20
               end
            end
         end
         TAC_PIN_LEVEL: begin
            if (pin_lvl || tm_min != 7'h00) begin
               src_d = TAC_IDLE; // see R4
            end
         end
         TAC_PIN_TIMED: begin
            if (minute_tick) begin
               if (min_left_q <= 7'h01) begin
                  src_d = TAC_IDLE; // see R7
               end else begin
                  min_left_d = min_left_q - 7'h01; // see R20
               end
            end
            if (tm_rise && pin_rise) begin
               src_d = TAC_IDLE; // see R6
            end
         end
         TAC_CMD: begin
            if (hit(reg_addr, `TAC_REG_CTRL)
               && !reg_wdata[`TAC_CTRL_TA]) begin
               src_d = TAC_IDLE; // see R2
            end
         end
         default: src_d = TAC_IDLE;
      endcase
      // pin-held flag: command value has no effect
      if (src_q == TAC_PIN_LEVEL || src_q == TAC_PIN_TIMED) begin
         cmd_ta_d = 1'b0; // see R1
      end else begin
         cmd_ta_d = (src_d == TAC_CMD);
      end
      if (prog_sw) begin
         src_d = TAC_IDLE; // see R3
         cmd_ta_d = 1'b0;
      end
      if (src_d != TAC_PIN_TIMED) begin
         min_left_d = 7'h00;
      end
   end

   // ----------------------------------------------------------
   // configuration and network flags
   // ----------------------------------------------------------
   always_comb begin
      tp_d = tp_q;
      net1_pin_d = net1_pin_q;
      tmout_d = tmout_q;
      net_en_d = net_en_q;
      net_tp_d = net_tp_q;
      net_ta_d = net_ta_q;
      name_d = name_q;
      sync_cnt_d = (sync_cnt_q != 24'h000000) ? sync_cnt_q - 24'h000001
         : sync_cnt_q;
      if (hit(reg_addr, `TAC_REG_CTRL)) begin
         tp_d = reg_wdata[`TAC_CTRL_TP];
         net1_pin_d = reg_wdata[`TAC_CTRL_NET1_PIN];
      end
      if (hit(reg_addr, `TAC_REG_TMOUT)) begin
         tmout_d = reg_wdata[7:0];
      end
      if (hit(reg_addr, `TAC_REG_NET_EN)) begin
         net_en_d = reg_wdata[`TAC_NETS-1:0]; // see R16
      end
      if (hit(reg_addr, `TAC_REG_NET_TP)) begin
         net_tp_d = reg_wdata[`TAC_NETS-1:0]; // see R18
      end
      if (hit(reg_addr, `TAC_REG_NET_TA)) begin
         net_ta_d = reg_wdata[`TAC_NETS-1:0];
      end
      if (net1_pin_d) begin
         net_ta_d[0] = ~pin_lvl; // see R8 R11
      end
      net_ta_d = net_guard(net_ta_d, net_en_d, net_tp_d); // see R10
      if (!tp_d) begin
         tmout_d = 8'h00; // see R9
      end
      if (hit(reg_addr, `TAC_REG_NAME_LO)) begin
         name_d[31:0] = reg_wdata;
         sync_cnt_d = 24'(`TAC_NAME_SYNC_CYC); // see R14
      end
      if (hit(reg_addr, `TAC_REG_NAME_HI)) begin
         name_d[63:32] = reg_wdata;
         sync_cnt_d = 24'(`TAC_NAME_SYNC_CYC);
      end
   end

   // ----------------------------------------------------------
   // outputs and read port
   // ----------------------------------------------------------
   always_comb begin
      ta_d = (src_d != TAC_IDLE);
      net_out_d = net_ta_d; // see R17
      eon_d = |net_ta_d; // see R12
      name_act_d = ta_d && (name_d != 64'h0) // see R13
         && (sync_cnt_d == 24'h000000);
      busy_d = (sync_cnt_d != 24'h000000);
      rdata_d = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `TAC_REG_CTRL: rdata_d = {28'h0000000, net1_pin_q, 1'b0,
               tp_q, ta_flag};
            `TAC_REG_TMOUT: rdata_d = {24'h000000, tmout_q};
            `TAC_REG_NET_EN: rdata_d = {28'h0000000, net_en_q};
            `TAC_REG_NET_TP: rdata_d = {28'h0000000, net_tp_q};
            `TAC_REG_NET_TA: rdata_d = {28'h0000000, net_ta_q};
            `TAC_REG_STATUS: rdata_d = {28'h0000000, name_busy,
               cmd_ta_q, src_q};
            `TAC_REG_MINLEFT: rdata_d = {25'h0000000, min_left_q};
            `TAC_REG_NAME_LO: rdata_d = name_q[31:0];
            `TAC_REG_NAME_HI: rdata_d = name_q[63:32];
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // net flags are volatile: reset clears, nothing persists (see R15)
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         src_q <= TAC_IDLE;
         cmd_ta_q <= 1'b0;
         min_left_q <= 7'h00;
         tp_q <= 1'b0;
         net1_pin_q <= 1'b0;
         tmout_q <= `TAC_TMOUT_RST;
         net_en_q <= 4'h0;
         net_tp_q <= 4'h0;
         net_ta_q <= 4'h0;
         name_q <= 64'h0;
         sync_cnt_q <= 24'h000000;
         rdata_q <= 32'h00000000;
         ta_flag <= 1'b0;
         tp_flag <= 1'b0;
         other_net_announce_flag <= 4'h0;
         eon_group_req <= 1'b0;
         name_active <= 1'b0;
         name_busy <= 1'b0;
      end else begin
         src_q <= src_d;
         cmd_ta_q <= cmd_ta_d;
         min_left_q <= min_left_d;
         tp_q <= tp_d;
         net1_pin_q <= net1_pin_d;
         tmout_q <= tmout_d;
         net_en_q <= net_en_d;
         net_tp_q <= net_tp_d;
         net_ta_q <= net_ta_d;
         name_q <= name_d;
         sync_cnt_q <= sync_cnt_d;
         rdata_q <= rdata_d;
         ta_flag <= ta_d;
         tp_flag <= tp_d;
         other_net_announce_flag <= net_out_d;
         eon_group_req <= eon_d;
         name_active <= name_act_d;
         name_busy <= busy_d;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   a_cmd_ignored: assert property ( // see R1
      @(posedge ref_clk) disable iff (!reset_n)
      (src_q == TAC_PIN_LEVEL && !pin_lvl && !prog_sw && tm_min == 7'h00)
      |=> src_q == TAC_PIN_LEVEL)
      else $error("pin-held flag lost to command");
   a_pin_ignored: assert property ( // see R2
      @(posedge ref_clk) disable iff (!reset_n)
      (src_q == TAC_CMD && !reg_wr) |=> src_q == TAC_CMD)
      else $error("command-held flag lost to pin");
   a_prog_clear: assert property ( // see R3
      @(posedge ref_clk) disable iff (!reset_n)
      prog_sw |=> !ta_flag)
      else $error("program switch did not clear flag");
   a_level_set: assert property ( // see R4
      @(posedge ref_clk) disable iff (!reset_n)
      (src_q == TAC_IDLE && tm_min == 7'h00 && !pin_lvl && !reg_wr
      && !net1_pin_q) |=> src_q == TAC_PIN_LEVEL)
      else $error("low level did not set flag");
   a_edge_load: assert property ( // see R5
      @(posedge ref_clk) disable iff (!reset_n)
      (src_q == TAC_IDLE && tm_min != 7'h00 && pin_fall && !reg_wr
      && !net1_pin_q) |=> min_left_q == $past(tm_min))
      else $error("minute counter not loaded");
   a_rise_clear: assert property ( // see R6
      @(posedge ref_clk) disable iff (!reset_n)
      (src_q == TAC_PIN_TIMED && tm_rise && pin_rise) |=> src_q == TAC_IDLE)
      else $error("rising edge did not clear");
   a_tick_only: assert property ( // see R7
      @(posedge ref_clk) disable iff (!reset_n)
      (src_q == TAC_PIN_TIMED && !minute_tick && !pin_rise && !reg_wr)
      |=> src_q == TAC_PIN_TIMED)
      else $error("timeout left off a minute tick");
   a_tp_zero: assert property ( // see R9
      @(posedge ref_clk) disable iff (!reset_n)
      !tp_q |-> tmout_q == 8'h00)
      else $error("timeout kept without traffic program");
   a_net_guard: assert property ( // see R10
      @(posedge ref_clk) disable iff (!reset_n)
      (net_ta_q & ~(net_en_q & net_tp_q)) == 4'h0)
      else $error("net flag set without guard");
   a_eon_req: assert property ( // see R12
      @(posedge ref_clk) disable iff (!reset_n)
      (|net_ta_q) |-> eon_group_req)
      else $error("14B request missing");
endmodule
`default_nettype wire

// >>> test_traffic_announcement_control.sv
// Purpose: self-checking bench for the announcement flag block
// Assumes: 25 MHz ref_clk, sync active-low reset
// Notes: name sync window too long to wait out, only its start is seen
`timescale 1ns/1ps
`default_nettype none
`include "tac_cfg.svh"
module test_traffic_announcement_control;
   import tac_pkg::*;
   typedef struct packed {
      logic [3:0] a;
      logic [7:0] d;
      logic p;
      logic [6:0] e;
   } tac_row_s;
   logic ref_clk, reset_n, minute_tick, reg_wr, reg_rd, press, wired;
   logic ta_pin, ta_flag, tp_flag, eon_group_req, name_active, name_busy;
   tac_addr_t reg_addr;
   tac_data_t reg_wdata, reg_rdata, rv;
   logic [`TAC_NETS-1:0] other_net_announce_flag;
   int n_fail, tests_run, cyc;
   tac_row_s rows [0:12];
   // ------------------------------------------------------------
   // design and partner
   // ------------------------------------------------------------
   tac_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .ta_pin(ta_pin),
      .minute_tick(minute_tick), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ta_flag(ta_flag), .tp_flag(tp_flag),
      .other_net_announce_flag(other_net_announce_flag),
      .eon_group_req(eon_group_req), .name_active(name_active),
      .name_busy(name_busy));
   tac_switch_model sw (.press(press), .wired(wired), .pin(ta_pin));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input tac_addr_t a, input tac_data_t d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input tac_addr_t a, output tac_data_t d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic tick();
      @(posedge ref_clk);
      minute_tick <= 1'b1;
      @(posedge ref_clk);
      minute_tick <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [31:0] outs();
      return {25'h0, ta_flag, tp_flag, eon_group_req,
         other_net_announce_flag};
   endfunction
   // ------------------------------------------------------------
   // clock and watchdog
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         end_sim();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {reset_n, minute_tick, reg_wr, reg_rd, press} = '0;
      {reg_addr, reg_wdata, n_fail, tests_run, cyc} = '0;
      wired = 1'b1;
      rows = '{'{4'h0, 8'h02, 1'b1, 7'h20}, '{4'h0, 8'h03, 1'b1, 7'h60},
         '{4'h0, 8'h02, 1'b1, 7'h20}, '{4'h2, 8'h0F, 1'b1, 7'h20},
         '{4'h4, 8'h0F, 1'b1, 7'h20}, '{4'h3, 8'h03, 1'b1, 7'h20},
         '{4'h4, 8'h0F, 1'b1, 7'h33}, '{4'h4, 8'h00, 1'b1, 7'h20},
         '{4'h2, 8'h00, 1'b1, 7'h20}, '{4'h3, 8'h0F, 1'b1, 7'h20},
         '{4'h4, 8'h0F, 1'b1, 7'h20}, '{4'h7, 8'hFF, 1'b0, 7'h60},
         '{4'h7, 8'hFF, 1'b1, 7'h20}};
      step(20);
      reset_n <= 1'b1;
      step(1);
      chk("outs after reset", outs(), 32'h0);
      rd(`TAC_REG_TMOUT, rv);
      chk("timeout reset", rv, {24'h0, `TAC_TMOUT_RST});
      foreach (rows[i]) begin
         wr(rows[i].a, {24'h0, rows[i].d});
         press <= ~rows[i].p;
         step(6);
         chk("row outs", outs(), {25'h0, rows[i].e});
      end
      // pin-held flag ignores command clear
      press <= 1'b1;
      step(6);
      wr(`TAC_REG_CTRL, 32'h2);
      step(3);
      chk("ta pin held", ta_flag, 1'b1);
      press <= 1'b0;
      step(6);
      chk("ta pin release", ta_flag, 1'b0);
      // command-held flag ignores the pin
      wr(`TAC_REG_CTRL, 32'h3);
      press <= 1'b1;
      step(6);
      press <= 1'b0;
      step(6);
      chk("ta cmd held", ta_flag, 1'b1);
      wr(`TAC_REG_CTRL, 32'h2);
      // timed mode, two minutes
      wr(`TAC_REG_TMOUT, 32'h2);
      rd(`TAC_REG_TMOUT, rv);
      chk("timeout value", rv, 32'h2);
      press <= 1'b1;
      step(6);
      chk("ta fall set", ta_flag, 1'b1);
      rd(`TAC_REG_MINLEFT, rv);
      chk("minutes loaded", rv, 32'h2);
      press <= 1'b0;
      step(50);
      chk("ta rise ignored", ta_flag, 1'b1);
      tick();
      step(3);
      chk("ta first tick", ta_flag, 1'b1);
      tick();
      step(3);
      chk("ta second tick", ta_flag, 1'b0);
      // program switch clears a pin-set flag
      press <= 1'b1;
      step(6);
      wr(`TAC_REG_CTRL, 32'h6);
      step(2);
      chk("ta program switch", ta_flag, 1'b0);
      press <= 1'b0;
      wr(`TAC_REG_CTRL, 32'h2);
      wr(`TAC_REG_TMOUT, 32'h82);
      step(6);
      press <= 1'b1;
      step(6);
      chk("ta fall set 130", ta_flag, 1'b1);
      press <= 1'b0;
      step(6);
      chk("ta rise clear", ta_flag, 1'b0);
      // traffic program off forces timeout zero
      wr(`TAC_REG_CTRL, 32'h0);
      rd(`TAC_REG_TMOUT, rv);
      chk("timeout forced", rv, 32'h0);
      wr(`TAC_REG_TMOUT, 32'h5);
      rd(`TAC_REG_TMOUT, rv);
      chk("timeout held zero", rv, 32'h0);
      // pin drives net1 as a level
      wr(`TAC_REG_NET_EN, 32'h1);
      wr(`TAC_REG_CTRL, 32'hA);
      wr(`TAC_REG_TMOUT, 32'h82);
      press <= 1'b1;
      step(6);
      chk("net1 pin set", outs(), 32'h31);
      press <= 1'b0;
      step(6);
      chk("net1 pin level", outs(), 32'h20);
      // traffic name, sync window starts and holds the name off
      wr(`TAC_REG_CTRL, 32'h3);
      step(2);
      chk("name empty", name_active, 1'b0);
      wr(`TAC_REG_NAME_LO, 32'h54524146);
      step(2);
      chk("name busy", name_busy, 1'b1);
      chk("name held off", name_active, 1'b0);
      rd(`TAC_REG_STATUS, rv);
      chk("status cmd busy", rv, 32'hF);
      // reset in mid-run, then an unwired contact
      reset_n <= 1'b0;
      step(3);
      reset_n <= 1'b1;
      step(1);
      chk("outs mid reset", outs(), 32'h0);
      chk("busy mid reset", name_busy, 1'b0);
      wired <= 1'b0;
      press <= 1'b1;
      step(6);
      chk("ta unwired", ta_flag, 1'b0);
      wired <= 1'b1;
      step(6);
      chk("ta wired low", ta_flag, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
